// File: pkg/gdoc_regs.vh
// field positions, command codes and reset values of the gate driver output control block
`ifndef GDOC_REGS_VH
`define GDOC_REGS_VH

// frame layout
`define GDOC_FRAME_BITS 16
`define GDOC_FRAME_STEP 8
`define GDOC_CMD_HI 15
`define GDOC_CMD_LO 11
`define GDOC_MSEL_HI 9
`define GDOC_MSEL_LO 6
`define GDOC_GEN_HI 8
`define GDOC_GEN_LO 6
`define GDOC_CH_HI 5
`define GDOC_CH_LO 0

// command codes in frame bits 15..11
`define GDOC_CMD_ONOFF 5'h09
`define GDOC_CMD_PINEN 5'h0a
`define GDOC_CMD_ANDOR 5'h0b

// status word positions
`define GDOC_ST_RESET 14
`define GDOC_ST_GD_HI 13
`define GDOC_ST_GD_LO 8

// reset values
`define GDOC_RST_ONOFF 6'h00
`define GDOC_RST_PINDIS 6'h00
`define GDOC_RST_ANDOR 6'h00
`define GDOC_RST_GEN 6'h00
`define GDOC_RST_MSEL 4'h0

`endif

// File: hdl/gdoc_sync2.v
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none

module gdoc_sync2 #(
   parameter WIDTH = 1,
   // reset level of each bit: the idle level of its pin, so no false edge follows reset
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   // clock and reset
   input wire clk,
   input wire arst_n,
   // data
   input wire [WIDTH-1:0] d,
   output reg [WIDTH-1:0] q
);

   reg [WIDTH-1:0] meta_reg;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// File: hdl/gdoc_top.v
// gate pre-driver output control: serial command decode, output merge, measure select, fault status
//
// Overview of operation
// - six gate outputs, pin or generator driven
// - off channel: drain below open threshold flags
// - on channel: drain above short threshold flags
// - gate faults shifted out in serial status
// - on/off bits 0-5 drive gates 1-6
// - on/off command code 01001, bit 10 ignored
// - select codes 0000,0111,1000,1001,1111 mean normal
// - other codes pick source and amplifier channels
// - measurement disables only the chosen pair
// - pin enable bit 0 enables, reset enabled
// - disabled pin ignores its combine setting
// - combine bit 0 ORs, 1 ANDs pin
// - generator enables in bits 8-6 of both
// - pin enable command code 01010 recognised
// - combine command code 01011 recognised
// - act only on 16 plus 8n clocks
// - execute command on chip select rise
// - default pin high: gates follow pins only
// - reset: outputs off, pins enabled and ORed
`timescale 1ns/1ps
`default_nettype none
`include "gdoc_regs.vh"

module gdoc_top #(
   parameter NCH = 6,
   parameter CNT_W = 8
) (
   // clock and reset
   input wire clk,
   input wire arst_n,
   // serial link from the host, sampled by clk
   input wire spi_sclk,
   input wire spi_cs_n,
   input wire spi_mosi,
   output reg spi_miso,
   output reg spi_miso_oe,
   // direct drive pins and mode pin
   input wire [NCH-1:0] direct_drive_pin,
   input wire default_mode_pin,
   // drain comparators and internal waveform
   input wire [NCH-1:0] drain_open_cmp,
   input wire [NCH-1:0] drain_short_cmp,
   input wire [NCH-1:0] gen_wave,
   // gate drive outputs
   output reg [NCH-1:0] gate_out,
   // load measurement routing, channel numbers 1..6, 0 for none
   output reg meas_active,
   output reg [2:0] meas_src_ch,
   output reg [2:0] meas_amp_ch,
   // generator enable to the frequency and duty engine
   output reg [NCH-1:0] gen_enable
);

   localparam SYNC_W = 3 + 1 + 3 * NCH;
   localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
   localparam integer FRAME_MIN_I = `GDOC_FRAME_BITS;
   localparam [CNT_W-1:0] FRAME_MIN = FRAME_MIN_I[CNT_W-1:0];

   // decode a 4-bit select into {active, source channel, amplifier channel}
   function [6:0] meas_decode;
      input [3:0] code;
      begin
         case (code)
            4'h1: meas_decode = {1'b1, 3'h1, 3'h2};
            4'h2: meas_decode = {1'b1, 3'h2, 3'h1};
            4'h3: meas_decode = {1'b1, 3'h3, 3'h4};
            4'h4: meas_decode = {1'b1, 3'h4, 3'h3};
            4'h5: meas_decode = {1'b1, 3'h5, 3'h6};
            4'h6: meas_decode = {1'b1, 3'h6, 3'h5};
            4'ha: meas_decode = {1'b1, 3'h2, 3'h1};
            4'hb: meas_decode = {1'b1, 3'h3, 3'h1};
            4'hc: meas_decode = {1'b1, 3'h4, 3'h1};
            4'hd: meas_decode = {1'b1, 3'h5, 3'h1};
            4'he: meas_decode = {1'b1, 3'h6, 3'h1};
            default: meas_decode = 7'h00;
         endcase
      end
   endfunction

   // one-hot mask for a channel number 1..6, zero for 0
   function [5:0] ch_mask;
      input [2:0] ch;
      begin
         case (ch)
            3'h1: ch_mask = 6'h01;
            3'h2: ch_mask = 6'h02;
            3'h3: ch_mask = 6'h04;
            3'h4: ch_mask = 6'h08;
            3'h5: ch_mask = 6'h10;
            3'h6: ch_mask = 6'h20;
            default: ch_mask = 6'h00;
         endcase
      end
   endfunction

   // synchronised pins
   wire [SYNC_W-1:0] sync_q;
   wire sclk_s;
   wire cs_n_s;
   wire mosi_s;
   wire dflt_s;
   wire [NCH-1:0] pin_s;
   wire [NCH-1:0] open_s;
   wire [NCH-1:0] short_s;

   // select resets to its idle high level, else a false select edge would clear the reset flag
   gdoc_sync2 #(
      .WIDTH(SYNC_W),
      .RST_VAL({1'b0, 1'b1, {(SYNC_W-2){1'b0}}})
   ) i_gdoc_sync2 (
      .clk(clk),
      .arst_n(arst_n),
      .d({spi_sclk, spi_cs_n, spi_mosi, default_mode_pin, direct_drive_pin, drain_open_cmp, drain_short_cmp}),
      .q(sync_q)
   );

   // the waveform comes from same-clock logic and is read directly
   assign sclk_s = sync_q[SYNC_W-1];
   assign cs_n_s = sync_q[SYNC_W-2];
   assign mosi_s = sync_q[SYNC_W-3];
   assign dflt_s = sync_q[SYNC_W-4];
   assign pin_s = sync_q[3*NCH-1:2*NCH];
   assign open_s = sync_q[2*NCH-1:NCH];
   assign short_s = sync_q[NCH-1:0];

   // serial link state
   reg sclk_d_reg;
   reg cs_n_d_reg;
   reg [15:0] shift_reg;
   reg [CNT_W-1:0] bit_cnt_reg;

   // command registers
   reg [NCH-1:0] onoff_reg;
   reg [3:0] msel_reg;
   reg [NCH-1:0] pin_dis_reg;
   reg [NCH-1:0] and_sel_reg;
   reg [NCH-1:0] gen_en_reg;

   // fault and status
   reg [NCH-1:0] fault_reg;
   reg reset_flag_reg;

   wire sclk_rise;
   wire sclk_fall;
   wire cs_fall;
   wire cs_rise;
   wire frame_ok;
   wire [4:0] cmd_code;
   wire [15:0] status_word;
   wire [6:0] meas_dec;
   wire [NCH-1:0] meas_mask;
   wire [NCH-1:0] fault_set;

   assign sclk_rise = sclk_s & ~sclk_d_reg & ~cs_n_s;
   assign sclk_fall = ~sclk_s & sclk_d_reg & ~cs_n_s;
   assign cs_fall = ~cs_n_s & cs_n_d_reg;
   assign cs_rise = cs_n_s & ~cs_n_d_reg;
   assign cmd_code = shift_reg[`GDOC_CMD_HI:`GDOC_CMD_LO];

   assign frame_ok = (bit_cnt_reg >= FRAME_MIN) && (bit_cnt_reg[2:0] == 3'h0) && (bit_cnt_reg != CNT_MAX);

   assign meas_dec = meas_decode(msel_reg);
   assign meas_mask = ch_mask(meas_dec[5:3]) | ch_mask(meas_dec[2:0]);

   assign fault_set = ((open_s & ~gate_out) | (short_s & gate_out)) & ~meas_mask;

   assign status_word = {1'b0, reset_flag_reg, fault_reg | fault_set, 8'h00};

   // serial shifter: status loads at select fall, host data shifts in behind it
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_d_reg <= 1'b0;
         cs_n_d_reg <= 1'b1;
         shift_reg <= 16'h0000;
         bit_cnt_reg <= {CNT_W{1'b0}};
         spi_miso <= 1'b0;
         spi_miso_oe <= 1'b0;
      end else begin
         sclk_d_reg <= sclk_s;
         cs_n_d_reg <= cs_n_s;
         spi_miso_oe <= ~cs_n_s;
         if (cs_fall) begin
            shift_reg <= status_word;
            bit_cnt_reg <= {CNT_W{1'b0}};
            spi_miso <= status_word[15];
         end else begin
            if (sclk_rise) begin
               shift_reg <= {shift_reg[14:0], mosi_s};
               // saturate so an over-long frame can never look valid again
               if (bit_cnt_reg != CNT_MAX) begin
                  bit_cnt_reg <= bit_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
               end
            end
            if (sclk_fall) begin
               spi_miso <= shift_reg[15];
            end
         end
      end
   end

   // command execution
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         onoff_reg <= `GDOC_RST_ONOFF;
         msel_reg <= `GDOC_RST_MSEL;
         pin_dis_reg <= `GDOC_RST_PINDIS;
         and_sel_reg <= `GDOC_RST_ANDOR;
         gen_en_reg <= `GDOC_RST_GEN;
      end else begin
         if (cs_rise && frame_ok) begin
            case (cmd_code)
               `GDOC_CMD_ONOFF: begin
                  onoff_reg <= shift_reg[`GDOC_CH_HI:`GDOC_CH_LO];
                  msel_reg <= shift_reg[`GDOC_MSEL_HI:`GDOC_MSEL_LO];
               end
               `GDOC_CMD_PINEN: begin
                  pin_dis_reg <= shift_reg[`GDOC_CH_HI:`GDOC_CH_LO];
                  gen_en_reg[2:0] <= {shift_reg[`GDOC_GEN_HI], shift_reg[`GDOC_GEN_HI-1], shift_reg[`GDOC_GEN_LO]};
               end
               `GDOC_CMD_ANDOR: begin
                  and_sel_reg <= shift_reg[`GDOC_CH_HI:`GDOC_CH_LO];
                  gen_en_reg[5:3] <= shift_reg[`GDOC_GEN_HI:`GDOC_GEN_LO];
               end
               default: begin
                  onoff_reg <= onoff_reg;
               end
            endcase
         end
      end
   end

   // fault latches: sticky until the status word is loaded for reading
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_reg <= {NCH{1'b0}};
         reset_flag_reg <= 1'b1;
      end else begin
         if (cs_fall) begin
            // a fault arriving in the load cycle stays set
            fault_reg <= fault_set;
            reset_flag_reg <= 1'b0;
         end else begin
            fault_reg <= fault_reg | fault_set;
         end
      end
   end

   // output merge
   reg [NCH-1:0] gate_next;
   reg serial_on;
   integer i;

   always @* begin
      gate_next = {NCH{1'b0}};
      serial_on = 1'b0;
      for (i = 0; i < NCH; i = i + 1) begin
         serial_on = onoff_reg[i] | (gen_en_reg[i] & gen_wave[i]);
         if (dflt_s) begin
            gate_next[i] = pin_s[i];
         end else if (meas_mask[i]) begin
            gate_next[i] = 1'b0;
         end else if (pin_dis_reg[i]) begin
            gate_next[i] = serial_on;
         end else if (and_sel_reg[i]) begin
            gate_next[i] = serial_on & pin_s[i];
         end else begin
            gate_next[i] = serial_on | pin_s[i];
         end
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gate_out <= {NCH{1'b0}};
         meas_active <= 1'b0;
         meas_src_ch <= 3'h0;
         meas_amp_ch <= 3'h0;
         gen_enable <= {NCH{1'b0}};
      end else begin
         gate_out <= gate_next;
         // routing is held off in default mode since the pair is not disabled there
         meas_active <= meas_dec[6] & ~dflt_s;
         meas_src_ch <= dflt_s ? 3'h0 : meas_dec[5:3];
         meas_amp_ch <= dflt_s ? 3'h0 : meas_dec[2:0];
         gen_enable <= gen_en_reg;
      end
   end

endmodule

`default_nettype wire

// File: tb/gdoc_host.sv
// serial host model that frames commands and collects status
`timescale 1ns/1ps
`default_nettype none
module gdoc_host (
   // serial link
   output logic sclk = 1'b0,
   output logic cs_n = 1'b1,
   output logic mosi = 1'b0,
   input wire logic miso
);
   logic [31:0] rx;
   task automatic xfer(input logic [31:0] w, input int n);
      rx = '0;
      cs_n = 1'b0;
      #200;
      for (int i = n - 1; i >= 0; i--) begin
         mosi = w[i];
         #80 sclk = 1'b1;
         rx = {rx[30:0], miso};
         #80 sclk = 1'b0;
      end
      #80 cs_n = 1'b1;
      // released line must not keep its last bit
      mosi = ~mosi;
      #300;
   endtask
endmodule
`default_nettype wire

// File: tb/gdoc_top_chk.sv
// port assertions for the gate driver output control block
`timescale 1ns/1ps
`default_nettype none
module gdoc_top_chk #(
   parameter NCH = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // serial link
   input wire logic spi_cs_n,
   input wire logic spi_miso,
   input wire logic spi_miso_oe,
   // pins
   input wire logic [NCH-1:0] direct_drive_pin,
   input wire logic default_mode_pin,
   // outputs
   input wire logic [NCH-1:0] gate_out,
   input wire logic meas_active,
   input wire logic [2:0] meas_src_ch,
   input wire logic [2:0] meas_amp_ch,
   input wire logic [NCH-1:0] gen_enable
);
   wire [7:0] pair = (8'h1 << meas_src_ch) | (8'h1 << meas_amp_ch);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   a_reset_gates_off: assert property ($rose(arst_n) |-> gate_out == '0 ##1 gate_out == '0)
      else $error("gates on after reset");
   a_cmd_after_cs: assert property ($changed(gen_enable) |-> spi_cs_n && $past(spi_cs_n, 2))
      else $error("register changed inside frame");
   a_default_pins: assert property ((default_mode_pin && $stable(direct_drive_pin)) [*6] |->
      gate_out == direct_drive_pin) else $error("gates not following pins");
   a_default_no_meas: assert property (default_mode_pin [*6] |-> !meas_active)
      else $error("measure active in default mode");
   a_meas_route: assert property (meas_active |-> meas_src_ch inside {[3'h1:3'h6]} &&
      meas_amp_ch inside {[3'h1:3'h6]} && meas_src_ch != meas_amp_ch) else $error("bad measure pair");
   a_idle_route: assert property ((!default_mode_pin) [*6] ##0 !meas_active |->
      meas_src_ch == 3'h0 && meas_amp_ch == 3'h0) else $error("route without measure");
   a_meas_pair_off: assert property (meas_active && $past(meas_active) && $stable(meas_src_ch) &&
      $stable(meas_amp_ch) |-> (pair[NCH:1] & gate_out) == '0) else $error("measured gate driven");
   a_oe_released: assert property (spi_cs_n [*5] |-> !spi_miso_oe)
      else $error("output enabled while deselected");
   a_oe_driven: assert property ((!spi_cs_n) [*5] |-> spi_miso_oe)
      else $error("output not enabled in frame");
   a_status_top: assert property ($rose(spi_miso_oe) |-> !spi_miso)
      else $error("status top bit set");
endmodule
bind gdoc_top gdoc_top_chk #(.NCH(NCH)) i_gdoc_top_chk (.clk, .arst_n, .spi_cs_n, .spi_miso, .spi_miso_oe,
   .direct_drive_pin, .default_mode_pin, .gate_out, .meas_active, .meas_src_ch, .meas_amp_ch, .gen_enable);
`default_nettype wire

// File: tb/test_gdoc_top.sv
// self-checking bench for the gate driver output control block
`timescale 1ns/1ps
`default_nettype none
module test_gdoc_top;
   localparam logic [63:0] src_tab = 64'h0654_3200_0654_3210;
   localparam logic [63:0] amp_tab = 64'h0111_1100_0563_4120;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic dflt = 1'b0;
   logic [5:0] pin = 6'h15;
   logic [5:0] opn = 6'h00;
   logic [5:0] sht = 6'h00;
   logic [5:0] wav = 6'h00;
   logic [5:0] on = 6'h00;
   logic [5:0] dis = 6'h00;
   logic [5:0] andm = 6'h00;
   logic [5:0] gm = 6'h00;
   wire sclk, cs_n, mosi, miso, oe, mact;
   wire [5:0] gate, gen;
   wire [2:0] src, amp;
   int n_mismatch = 0;
   int tests_run = 0;
   gdoc_host i_gdoc_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
   gdoc_top i_gdoc_top (.clk(clk), .arst_n(arst_n), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
      .spi_miso(miso), .spi_miso_oe(oe), .direct_drive_pin(pin), .default_mode_pin(dflt),
      .drain_open_cmp(opn), .drain_short_cmp(sht), .gen_wave(wav), .gate_out(gate),
      .meas_active(mact), .meas_src_ch(src), .meas_amp_ch(amp), .gen_enable(gen));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic send(input logic [31:0] w, input int n);
      i_gdoc_host.xfer(w, n);
      repeat (10) @(negedge clk);
   endtask
   // a disabled pin passes the serial path alone; an AND bit makes the pin gate the serial path
   function automatic logic [5:0] want();
      logic [5:0] b;
      logic [5:0] g;
      b = on | (gm & wav);
      g = dis | andm;
      return dflt ? pin : (g & b & (dis | pin)) | (~g & (b | pin));
   endfunction
   initial begin
      #500000;
      n_mismatch++;
      complete_run();
   end
   initial begin
      logic [3:0] s;
      logic [3:0] a;
      logic [6:0] m;
      repeat (6) @(negedge clk);
      arst_n = 1'b1;
      repeat (10) @(negedge clk);
      chk(16'(gate), 16'h0015);
      on = 6'h2a;
      send(32'h4c2a, 16);
      chk(i_gdoc_host.rx[15:0], 16'h4000);
      chk(16'(gate), 16'(want()));
      send(32'h4800, 17);
      chk(16'(gate), 16'(want()));
      andm = 6'h03;
      send(32'h1234_5803, 32);
      chk(i_gdoc_host.rx[31:16], 16'h0000);
      chk(i_gdoc_host.rx[15:0], 16'h1234);
      chk(16'(gate), 16'(want()));
      dis = 6'h07;
      gm = 6'h07;
      wav = 6'h05;
      send(32'h57c7, 16);
      chk(16'(gen), 16'h0007);
      chk(16'(gate), 16'(want()));
      wav = 6'h00;
      repeat (4) @(negedge clk);
      chk(16'(gate), 16'(want()));
      gm = 6'h3f;
      send(32'h59c3, 16);
      chk(16'(gen), 16'h003f);
      on = 6'h3f;
      for (int c = 0; c < 16; c++) begin
         s = src_tab[c*4 +: 4];
         a = amp_tab[c*4 +: 4];
         m = (7'h1 << s) | (7'h1 << a);
         send(32'h483f | (c << 6), 16);
         chk(16'({mact, src, amp}), 16'({s != 4'h0, s[2:0], a[2:0]}));
         chk(16'(gate), 16'(want() & ~m[6:1]));
      end
      pin = 6'h00;
      on = 6'h01;
      send(32'h4801, 16);
      opn = 6'h03;
      sht = 6'h05;
      repeat (10) @(negedge clk);
      send(32'h4801, 16);
      chk(i_gdoc_host.rx[15:0], 16'h0300);
      opn = 6'h00;
      sht = 6'h00;
      send(32'h4801, 16);
      chk(i_gdoc_host.rx[15:0], 16'h0300);
      send(32'h4801, 16);
      chk(i_gdoc_host.rx[15:0], 16'h0000);
      send(32'h4841, 16);
      dflt = 1'b1;
      pin = 6'h0c;
      repeat (10) @(negedge clk);
      chk(16'(gate), 16'(want()));
      chk(16'({mact, src, amp}), 16'h0000);
      dflt = 1'b0;
      repeat (10) @(negedge clk);
      chk(16'(gate), 16'(want() & ~6'h03));
      chk(16'({mact, src, amp}), 16'h004a);
      // a second reset in mid-run must bring back the power-on state
      arst_n = 1'b0;
      on = 6'h00;
      dis = 6'h00;
      andm = 6'h00;
      gm = 6'h00;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      repeat (10) @(negedge clk);
      chk(16'(gate), 16'(want()));
      chk(16'({gen, mact}), 16'h0000);
      send(32'h4800, 16);
      chk(i_gdoc_host.rx[15:0], 16'h4000);
      complete_run();
   end
endmodule
`default_nettype wire
